// File: shared/udpfc_pkg.sv
// Package for the up/down and paired frequency counter channel.
// Assumes a single 10 MHz clock; all pins are synchronised inside the block.
// Overview of operation
// - Up/down mode: rising edge on up input adds one to the count.
// - Up/down mode: rising edge on down input subtracts one from the count.
// - Each sample clock with room in the FIFO publishes the up/down count without disturbing counting.
// - Measurement start clears counters when the reset-on-start option is set.
// - Period mode counts time-base cycles between input edges, plus or minus one.
// - Paired frequency mode uses fixed adjacent counters, even channel with odd.
// - Paired mode: first counter counts rising edges of the count source input.
// - Paired mode: second counter counts every rising edge of the time base.
// - Paired mode: each source rising edge captures the second counter into a holding register.
// - Each sample clock with room in the FIFO publishes both paired counter values in one sample.
package udpfc_pkg;
  localparam int CNT_W        = 32;
  localparam int FIFO_W       = 3 * CNT_W + 2;
  localparam int FIFO_DEPTH   = 8;
  localparam int CLK_HZ       = 10_000_000;
  localparam int TBASE_HZ     = 10_000_000;
  // Time-base enable divide ratio, at least one cycle.
  localparam int TBASE_DIV    = (CLK_HZ / TBASE_HZ) < 1 ? 1 : (CLK_HZ / TBASE_HZ);
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    UDPFC_MODE_UPDOWN = 3'h1,
    UDPFC_MODE_PERIOD = 3'h2,
    UDPFC_MODE_FREQ   = 3'h4
  } udpfc_mode_e;

  typedef struct packed {
    logic [1:0]       mode_tag;
    logic [CNT_W-1:0] first_cnt;
    logic [CNT_W-1:0] second_cnt;
    logic [CNT_W-1:0] hold_cnt;
  } udpfc_sample_s;
endpackage

// File: logic/udpfc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock shared by writer and reader.
`timescale 1ns/1ps
module udpfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   level;
  } udpfc_fifo_s;
  udpfc_fifo_s         st_reg;
  udpfc_fifo_s         st_next;
  logic    [WIDTH-1:0] mem [DEPTH];
  logic                push;
  logic                pop;

  assign in_ready  = (st_reg.level != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.level != '0);
  assign out_data  = mem[st_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.level = st_reg.level + 1'b1;
    end else if (pop && !push) begin
      st_next.level = st_reg.level - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end
endmodule

// File: logic/udpfc_counter.sv
// Counter channel pair: up/down event counting, period and paired frequency measurement.
// Assumes pin inputs are asynchronous to clk; samples leave through an 8-word FIFO.
`timescale 1ns/1ps
module udpfc_counter (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     count_source_input,
  input  wire logic                     count_direction_aux_input,
  input  wire logic                     sample_clk_in,
  input  wire logic                     start_in,
  input  wire logic                     reset_on_start,
  input  wire udpfc_pkg::udpfc_mode_e   mode_sel,
  output udpfc_pkg::udpfc_sample_s      sample_data,
  output logic                          sample_valid,
  input  wire logic                     sample_ready,
  output logic                          sample_overrun
);
  import udpfc_pkg::*;

  typedef struct packed {
    logic [1:0]       src_sync;
    logic [1:0]       aux_sync;
    logic [1:0]       smp_sync;
    logic [1:0]       start_sync;
    logic             src_last;
    logic             aux_last;
    logic             smp_last;
    logic             start_last;
    logic [7:0]       div_cnt;
    logic [CNT_W-1:0] first_cnt;
    logic [CNT_W-1:0] second_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic             overrun;
  } udpfc_state_s;

  udpfc_state_s   st_reg;
  udpfc_state_s   st_next;
  udpfc_sample_s  push_word;
  logic           push_valid;
  logic           push_ready;
  logic           src_rise;
  logic           aux_rise;
  logic           smp_rise;
  logic           start_rise;
  logic           tbase_en;
  logic           start_clr;
  udpfc_sample_s  fifo_word;

  function automatic logic rise(input logic [1:0] sync, input logic last);
    rise = sync[1] && !last;
  endfunction

  // Edge detectors look only at the second synchroniser stage.
  assign src_rise   = rise(st_reg.src_sync, st_reg.src_last);
  assign aux_rise   = rise(st_reg.aux_sync, st_reg.aux_last);
  assign smp_rise   = rise(st_reg.smp_sync, st_reg.smp_last);
  assign start_rise = rise(st_reg.start_sync, st_reg.start_last);
  assign tbase_en   = (st_reg.div_cnt == 8'(TBASE_DIV - 1));
  assign start_clr  = start_rise && reset_on_start;

  always_comb begin
    st_next            = st_reg;
    st_next.src_sync   = {st_reg.src_sync[0], count_source_input};
    st_next.aux_sync   = {st_reg.aux_sync[0], count_direction_aux_input};
    st_next.smp_sync   = {st_reg.smp_sync[0], sample_clk_in};
    st_next.start_sync = {st_reg.start_sync[0], start_in};
    st_next.src_last   = st_reg.src_sync[1];
    st_next.aux_last   = st_reg.aux_sync[1];
    st_next.smp_last   = st_reg.smp_sync[1];
    st_next.start_last = st_reg.start_sync[1];
    st_next.div_cnt    = tbase_en ? 8'h00 : st_reg.div_cnt + 8'h01;
    unique case (mode_sel)
      UDPFC_MODE_UPDOWN: begin
        if (src_rise && !aux_rise) begin
          st_next.first_cnt = st_reg.first_cnt + 1'b1;
        end else if (aux_rise && !src_rise) begin
          st_next.first_cnt = st_reg.first_cnt - 1'b1;
        end
        // Both edges together fall through and cancel.
      end
      UDPFC_MODE_PERIOD: begin
        // Time base counts between source edges; phase gives the one-cycle spread.
        if (src_rise) begin
          st_next.hold_cnt   = st_reg.second_cnt + 1'b1;
          st_next.second_cnt = '0;
        end else if (tbase_en) begin
          st_next.second_cnt = st_reg.second_cnt + 1'b1;
        end
      end
      UDPFC_MODE_FREQ: begin
        // This channel is the even/odd pair as one unit.
        if (src_rise) begin
          st_next.first_cnt = st_reg.first_cnt + 1'b1;
          st_next.hold_cnt  = st_reg.second_cnt;
        end
        if (tbase_en) begin
          st_next.second_cnt = st_reg.second_cnt + 1'b1;
        end
      end
      default: begin
        st_next.first_cnt = st_reg.first_cnt;
      end
    endcase
    if (start_clr) begin
      st_next.first_cnt  = CNT_RST;
      st_next.second_cnt = CNT_RST;
      st_next.hold_cnt   = CNT_RST;
    end
    // Sticky: a sample lost to a full FIFO stays flagged until reset.
    if (smp_rise && !push_ready) begin
      st_next.overrun = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // The snapshot is taken from current registers only, so counting is never stalled.
  always_comb begin
    push_word.mode_tag   = mode_sel[2] ? 2'h2 : (mode_sel[1] ? 2'h1 : 2'h0);
    push_word.first_cnt  = st_reg.first_cnt;
    push_word.second_cnt = st_reg.second_cnt;
    push_word.hold_cnt   = st_reg.hold_cnt;
    push_valid           = smp_rise;
  end

  udpfc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (push_word),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (fifo_word),
    .out_valid (sample_valid),
    .out_ready (sample_ready)
  );

  assign sample_data    = fifo_word;
  assign sample_overrun = st_reg.overrun;

  a_updown_inc : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && src_rise && !aux_rise && !(start_rise && reset_on_start))
      |=> st_reg.first_cnt == $past(st_reg.first_cnt) + 1'b1)
    else $error("Up edge did not increment the count.");
  a_updown_dec : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && aux_rise && !src_rise && !(start_rise && reset_on_start))
      |=> st_reg.first_cnt == $past(st_reg.first_cnt) - 1'b1)
    else $error("Down edge did not decrement the count.");
  a_updown_cancel : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && aux_rise && src_rise && !(start_rise && reset_on_start))
      |=> $stable(st_reg.first_cnt))
    else $error("Simultaneous edges changed the count.");
  a_sample_push : assert property (@(posedge clk) disable iff (rst)
    smp_rise |-> push_valid && push_word.first_cnt == st_reg.first_cnt)
    else $error("Sample did not carry the live count.");
  a_start_clear : assert property (@(posedge clk) disable iff (rst)
    (start_rise && reset_on_start) |=> st_reg.first_cnt == '0 && st_reg.hold_cnt == '0)
    else $error("Start did not clear the counters.");
  a_period_hold : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_PERIOD && src_rise && !start_rise) |=> st_reg.second_cnt == '0)
    else $error("Period count did not restart on edge.");
  a_freq_src : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_FREQ && src_rise && !start_rise)
      |=> st_reg.first_cnt == $past(st_reg.first_cnt) + 1'b1)
    else $error("Source edge not counted in frequency mode.");
  a_freq_tbase : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_FREQ && tbase_en && !start_rise)
      |=> st_reg.second_cnt == $past(st_reg.second_cnt) + 1'b1)
    else $error("Time base not counted in frequency mode.");
  a_freq_capture : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_FREQ && src_rise && !start_rise)
      |=> st_reg.hold_cnt == $past(st_reg.second_cnt))
    else $error("Holding register missed the capture.");
  a_pair_sample : assert property (@(posedge clk) disable iff (rst)
    smp_rise |-> push_word.second_cnt == st_reg.second_cnt && push_word.hold_cnt == st_reg.hold_cnt)
    else $error("Paired values not in one sample.");

  // The checks below leave out a start clear wherever it would override the counting step,
  // because a start with reset-on-start wins over every count in the same cycle.
  a_updown_idle : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && !src_rise && !aux_rise && !start_clr)
      |=> $stable(st_reg.first_cnt))
    else $error("Count moved without an up or down edge.");

  a_updown_pair : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && !start_clr)
      |=> $stable(st_reg.second_cnt) && $stable(st_reg.hold_cnt))
    else $error("Up/down counting touched the paired counters.");

  a_start_keep : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_UPDOWN && start_rise && !reset_on_start && !src_rise && !aux_rise)
      |=> $stable(st_reg.first_cnt))
    else $error("Start cleared the count with the option off.");

  a_start_second : assert property (@(posedge clk) disable iff (rst)
    start_clr
      |=> st_reg.second_cnt == '0)
    else $error("Start did not clear the time-base counter.");

  a_period_value : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_PERIOD && src_rise && !start_clr)
      |=> st_reg.hold_cnt == $past(st_reg.second_cnt) + 1'b1)
    else $error("Period result is not the cycles between edges.");

  a_period_count : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_PERIOD && !src_rise && tbase_en && !start_clr)
      |=> st_reg.second_cnt == $past(st_reg.second_cnt) + 1'b1)
    else $error("Period counter missed a time-base cycle.");

  a_period_keep : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_PERIOD && !src_rise && !start_clr)
      |=> $stable(st_reg.hold_cnt) && $stable(st_reg.first_cnt))
    else $error("Period result changed between source edges.");

  a_freq_idle : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_FREQ && !src_rise && !start_clr)
      |=> $stable(st_reg.first_cnt))
    else $error("Edge counter moved without a source edge.");

  a_freq_hold_keep : assert property (@(posedge clk) disable iff (rst)
    (mode_sel == UDPFC_MODE_FREQ && !src_rise && !start_clr)
      |=> $stable(st_reg.hold_cnt))
    else $error("Holding register changed without a source edge.");

  // Each pin edge must have passed both synchroniser stages before any logic acts on it.
  a_src_sync : assert property (@(posedge clk) disable iff (rst)
    src_rise
      |-> $past(count_source_input, 2))
    else $error("Source edge seen without two synchroniser stages.");

  a_aux_sync : assert property (@(posedge clk) disable iff (rst)
    aux_rise
      |-> $past(count_direction_aux_input, 2))
    else $error("Down edge seen without two synchroniser stages.");

  a_start_sync : assert property (@(posedge clk) disable iff (rst)
    start_rise
      |-> $past(start_in, 2))
    else $error("Start edge seen without two synchroniser stages.");

  a_smp_sync : assert property (@(posedge clk) disable iff (rst)
    smp_rise
      |-> $past(sample_clk_in, 2))
    else $error("Sample edge seen without two synchroniser stages.");

  a_src_once : assert property (@(posedge clk) disable iff (rst)
    src_rise
      |=> !src_rise)
    else $error("One source edge was counted twice.");

  a_smp_once : assert property (@(posedge clk) disable iff (rst)
    smp_rise
      |=> !push_valid)
    else $error("One sample edge pushed two words.");

  // The overrun flag is set only by a dropped sample and is cleared only by reset.
  a_overrun_set : assert property (@(posedge clk) disable iff (rst)
    (smp_rise && !push_ready)
      |=> sample_overrun)
    else $error("Dropped sample did not raise the overrun flag.");

  a_overrun_sticky : assert property (@(posedge clk) disable iff (rst)
    sample_overrun
      |=> sample_overrun)
    else $error("Overrun flag fell without a reset.");

  a_overrun_quiet : assert property (@(posedge clk) disable iff (rst)
    (!sample_overrun && !(smp_rise && !push_ready))
      |=> !sample_overrun)
    else $error("Overrun flag rose without a dropped sample.");

  a_sample_queued : assert property (@(posedge clk) disable iff (rst)
    (smp_rise && push_ready)
      |=> sample_valid)
    else $error("Accepted sample did not reach the output.");

  a_fifo_stand : assert property (@(posedge clk) disable iff (rst)
    (sample_valid && !sample_ready)
      |=> sample_valid && $stable(sample_data))
    else $error("Unread sample word did not stand.");

  // The mode tag lets the sampler tell the three result layouts apart.
  a_tag_updown : assert property (@(posedge clk) disable iff (rst)
    (smp_rise && mode_sel == UDPFC_MODE_UPDOWN)
      |-> push_word.mode_tag == 2'h0)
    else $error("Up/down sample carries the wrong mode tag.");

  a_tag_period : assert property (@(posedge clk) disable iff (rst)
    (smp_rise && mode_sel == UDPFC_MODE_PERIOD)
      |-> push_word.mode_tag == 2'h1)
    else $error("Period sample carries the wrong mode tag.");

  a_tag_freq : assert property (@(posedge clk) disable iff (rst)
    (smp_rise && mode_sel == UDPFC_MODE_FREQ)
      |-> push_word.mode_tag == 2'h2)
    else $error("Frequency sample carries the wrong mode tag.");
endmodule

// File: tb/udpfc_src_model.sv
// Pulse source and sample-clock source standing at the pins of the counter channel.
// Assumes pulse() is called just after a rising clk edge; each call takes six cycles.
`timescale 1ns/1ps
module udpfc_src_model (
  input  wire logic clk,
  output logic      src,
  output logic      aux,
  output logic      smp,
  output logic      st
);
  logic [3:0] p;
  initial p = 4'h0;
  assign {st, smp, aux, src} = p;
  // Three cycles high and three low keep every edge well clear of the two-flop synchroniser.
  task automatic pulse(input logic [3:0] m);
    p <= m;
    repeat (3) @(posedge clk);
    p <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// File: tb/udpfc_counter_test.sv
// Self-checking bench for the counter channel: up/down, period, paired frequency and FIFO.
// Assumes the pin model above; the sampler side is driven here through sample_ready.
`timescale 1ns/1ps
module udpfc_counter_test;
  import udpfc_pkg::*;
  logic          clk;
  logic          rst;
  logic          ros;
  logic          ready;
  udpfc_mode_e   mode;
  logic          src, aux, smp, st, sv, ovr;
  udpfc_sample_s sd, w0, w1, w2;
  int            err_total = 0;
  int            n_tests = 0;
  udpfc_src_model i_src (.clk(clk), .src(src), .aux(aux), .smp(smp), .st(st));
  udpfc_counter i_dut (
    .clk(clk), .rst(rst), .count_source_input(src), .count_direction_aux_input(aux),
    .sample_clk_in(smp), .start_in(st), .reset_on_start(ros), .mode_sel(mode),
    .sample_data(sd), .sample_valid(sv), .sample_ready(ready), .sample_overrun(ovr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Words are taken on the falling edge; ready is then raised for exactly one edge to pop the head.
  task automatic snap(output udpfc_sample_s w);
    int i;
    i_src.pulse(4'h4);
    @(negedge clk);
    for (i = 0; i < 20 && sv !== 1'b1; i++) @(negedge clk);
    check({31'h0, sv}, 32'h1);
    if (sv !== 1'b1) complete_run();
    w = sd;
    @(posedge clk);
    ready <= 1'b1;
    @(posedge clk);
    ready <= 1'b0;
  endtask
  task automatic t_updown();
    mode <= UDPFC_MODE_UPDOWN;
    ros <= 1'b1;
    i_src.pulse(4'h8);
    repeat (3) i_src.pulse(4'h1);
    i_src.pulse(4'h2);
    i_src.pulse(4'h3);
    snap(w0);
    check(w0.first_cnt, 32'h2);
    check({30'h0, w0.mode_tag}, 32'h0);
    snap(w0);
    check(w0.first_cnt, 32'h2);
    ros <= 1'b0;
    i_src.pulse(4'h8);
    snap(w0);
    check(w0.first_cnt, 32'h2);
    ros <= 1'b1;
    i_src.pulse(4'h8);
    snap(w0);
    check(w0.first_cnt, 32'h0);
  endtask
  task automatic t_period();
    mode <= UDPFC_MODE_PERIOD;
    i_src.pulse(4'h8);
    repeat (3) i_src.pulse(4'h1);
    snap(w0);
    check({31'h0, w0.hold_cnt >= 32'h5 && w0.hold_cnt <= 32'h7}, 32'h1);
    check({30'h0, w0.mode_tag}, 32'h1);
  endtask
  // A snapshot takes eight cycles and a source pulse six, so like events lie fourteen apart.
  task automatic t_freq();
    mode <= UDPFC_MODE_FREQ;
    i_src.pulse(4'h8);
    snap(w0);
    i_src.pulse(4'h1);
    snap(w1);
    i_src.pulse(4'h1);
    snap(w2);
    check(w1.first_cnt, 32'h1);
    check(w2.first_cnt - w1.first_cnt, 32'h1);
    check(w2.second_cnt - w1.second_cnt, 32'he);
    check(w2.hold_cnt - w1.hold_cnt, 32'he);
    check({30'h0, w2.mode_tag}, 32'h2);
  endtask
  task automatic t_fifo();
    int i;
    int n;
    n = 0;
    ready <= 1'b0;
    repeat (8) i_src.pulse(4'h4);
    check({31'h0, ovr}, 32'h0);
    i_src.pulse(4'h4);
    check({31'h0, ovr}, 32'h1);
    ready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (sv === 1'b1) n++;
    end
    check(n, 32'h8);
  endtask
  // A reset in mid-run must drop the queued word, the sticky overrun flag and every count.
  task automatic t_reset();
    @(posedge clk);
    ready <= 1'b0;
    i_src.pulse(4'h5);
    check({30'h0, ovr, sv}, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({30'h0, ovr, sv}, 32'h0);
    @(posedge clk);
    snap(w0);
    check(w0.first_cnt, 32'h0);
    check(w0.hold_cnt, 32'h0);
    check(w0.second_cnt, 32'h3);
  endtask
  initial begin
    rst   = 1'b1;
    ros   = 1'b0;
    ready = 1'b0;
    mode  = UDPFC_MODE_UPDOWN;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_updown();
    t_period();
    t_freq();
    t_fifo();
    t_reset();
    complete_run();
  end
endmodule
